// ==== logic/gpp_params.svh ====
// gpp_params.svh: addresses, reset values, masks and codes for the ports
// assumes a 16-bit cpu address and 8-bit data on the register port
`ifndef GPP_PARAMS_SVH
`define GPP_PARAMS_SVH
// ==========================================================
// register addresses
`define GPP_ADDR_LAT0 16'hff00
`define GPP_ADDR_LAT2 16'hff02
`define GPP_ADDR_LAT3 16'hff03
`define GPP_ADDR_LAT4 16'hff04
`define GPP_ADDR_LAT12 16'hff0c
`define GPP_ADDR_LAT13 16'hff0d
`define GPP_ADDR_DIR0 16'hff20
`define GPP_ADDR_DIR2 16'hff22
`define GPP_ADDR_DIR3 16'hff23
`define GPP_ADDR_DIR4 16'hff24
`define GPP_ADDR_DIR12 16'hff2c
`define GPP_ADDR_PU0 16'hff30
`define GPP_ADDR_PU2 16'hff32
`define GPP_ADDR_PU3 16'hff33
`define GPP_ADDR_PU4 16'hff34
`define GPP_ADDR_PORT12_PULLUP_SELECT 16'hff3c
`define GPP_ADDR_AN2 16'hff42
// ==========================================================
// reset values and masks
`define GPP_DIR_RST 8'hff
`define GPP_REG_RST 8'h00
`define GPP_KEEP4 8'h0f
`define GPP_KEEP1 8'h01
`define GPP_KEEP8 8'hff
`define GPP_FIX_DIR4 8'hf0
`define GPP_FIX_NONE 8'h00
`define GPP_PORT12_PULLUP_SELECT_MASK 4'h9
// ==========================================================
// option setting: cycles after release before it is read
`define GPP_OPT_WAIT_CYC 4
`endif

// ==== logic/gpp_pkg.sv ====
// gpp_pkg.sv: types shared by the port block
// assumes nothing of its surroundings
package gpp_pkg;
  typedef enum logic [1:0] {
    GPP_LOAD = 2'b00,
    GPP_CHECK = 2'b01,
    GPP_RUN = 2'b11
  } gpp_state_t;
  typedef enum logic [1:0] {
    GPP_OSC_INT = 2'h0,
    GPP_OSC_XTAL = 2'h1,
    GPP_OSC_EXT = 2'h2
  } gpp_osc_t;
endpackage

// ==== logic/gpp_sync.sv ====
// gpp_sync.sv: two-flop synchroniser for a vector of pin levels
// assumes each bit is an independent level; no bus coherence
`timescale 1ns/1ps
module gpp_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta;
  initial begin
    if (W < 1) $error("gpp_sync width must be at least 1");
  end
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta <= '0;
      q_out <= '0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule

// ==== logic/gpp_ports.sv ====
// gpp_ports.sv: port registers, pin drivers and pin-sharing hooks
// assumes pads resolve out/oe/pull-up; option setting is stable from reset
`timescale 1ns/1ps
`include "gpp_params.svh"
module gpp_ports import gpp_pkg::*; #(
  parameter int OPT_WAIT = `GPP_OPT_WAIT_CYC
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic [15:0] cpu_addr_in,
  input wire logic cpu_wr_in,
  input wire logic cpu_rd_in,
  input wire logic cpu_bit_in,
  input wire logic [2:0] cpu_bit_sel_in,
  input wire logic [7:0] cpu_wdata_in,
  output logic [7:0] cpu_rdata_out,
  input wire logic opt_reset_pin_is_port_in,
  input wire logic [1:0] opt_osc_sel_in,
  output logic core_reset_n_out,
  input wire logic [3:0] p0_pin_in,
  output logic [3:0] p0_pin_out,
  output logic [3:0] p0_pin_oe_out,
  output logic [3:0] p0_pullup_out,
  input wire logic [3:0] p2_pin_in,
  output logic [3:0] p2_pin_out,
  output logic [3:0] p2_pin_oe_out,
  output logic [3:0] p2_pullup_out,
  output logic [3:0] port2_analog_select_out,
  input wire logic [3:0] p3_pin_in,
  output logic [3:0] p3_pin_out,
  output logic [3:0] p3_pin_oe_out,
  output logic [3:0] p3_pullup_out,
  input wire logic reset_shared_input_pin_in,
  input wire logic [7:0] p4_pin_in,
  output logic [7:0] p4_pin_out,
  output logic [7:0] p4_pin_oe_out,
  output logic [7:0] p4_pullup_out,
  input wire logic [3:0] p12_pin_in,
  output logic [3:0] p12_pin_out,
  output logic [3:0] p12_pin_oe_out,
  output logic [3:0] p12_pullup_out,
  output logic substitute_reset_output_pin_out,
  input wire logic timer_output_a_in,
  input wire logic timer_output_b_in,
  input wire logic serial_transmit_pin_in,
  output logic timer_capture_input_a_out,
  output logic timer_capture_input_b_out,
  output logic ext_irq_a_out,
  output logic ext_irq_b_out,
  output logic ext_irq_c_out,
  output logic ext_irq_d_out,
  output logic serial_receive_pin_out
);
  initial begin
    if (OPT_WAIT < 1 || OPT_WAIT > 255) $error("OPT_WAIT out of range");
  end
  // ==========================================================
  // pin synchronisers
  logic [3:0] s0, s2, s3, s12;
  logic [7:0] s4;
  logic s_rst;
  gpp_sync #(.W(25)) u_sync (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .d_in({p0_pin_in, p2_pin_in, p3_pin_in, reset_shared_input_pin_in,
           p4_pin_in, p12_pin_in}),
    .q_out({s0, s2, s3, s_rst, s4, s12})
  );
  // ==========================================================
  // option load and reset hold
  gpp_state_t state;
  logic [7:0] wait_cnt;
  logic rst_is_port;
  gpp_osc_t osc;
  logic core_hold;
  logic pin_reset;
  assign core_hold = (state != GPP_RUN);
  assign pin_reset = !rst_is_port && !s_rst;
  // option captured only after release; async reset takes constants
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= GPP_LOAD;
      wait_cnt <= 8'h00;
      rst_is_port <= 1'b0;
      osc <= GPP_OSC_INT;
    end else begin
      case (state)
        GPP_LOAD: begin
          wait_cnt <= wait_cnt + 8'h01;
          if (wait_cnt == 8'(OPT_WAIT - 1)) begin
            rst_is_port <= opt_reset_pin_is_port_in;
            osc <= gpp_osc_t'(opt_osc_sel_in);
            state <= GPP_CHECK;
          end
        end
        GPP_CHECK: begin
          if (!pin_reset) state <= GPP_RUN;
        end
        GPP_RUN: begin
          if (pin_reset) state <= GPP_CHECK;
        end
        default: state <= GPP_LOAD;
      endcase
    end
  end
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) core_reset_n_out <= 1'b0;
    else core_reset_n_out <= !core_hold;
  end
  // ==========================================================
  // register writes
  function automatic logic [7:0] upd(input logic [7:0] old,
                                     input logic [7:0] keep,
                                     input logic [7:0] fix);
    logic [7:0] v;
    v = old;
    if (cpu_bit_in) v[cpu_bit_sel_in] = cpu_wdata_in[0];
    else v = cpu_wdata_in;
    upd = (v & keep) | fix;
  endfunction
  function automatic logic [7:0] rdv(input logic [7:0] dir,
                                     input logic [7:0] lat,
                                     input logic [7:0] pin);
    rdv = (dir & pin) | (~dir & lat);
  endfunction
  logic [7:0] dir0, dir2, dir3, dir4, dir12;
  logic [7:0] lat0, lat2, lat3, lat4, lat12, lat13;
  logic [7:0] pu0, pu2, pu3, pu4, port12_pullup_select, an2;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dir0 <= `GPP_DIR_RST;
      dir2 <= `GPP_DIR_RST;
      dir3 <= `GPP_DIR_RST;
      dir4 <= `GPP_DIR_RST;
      dir12 <= `GPP_DIR_RST;
    end else if (core_hold) begin
      dir0 <= `GPP_DIR_RST;
      dir2 <= `GPP_DIR_RST;
      dir3 <= `GPP_DIR_RST;
      dir4 <= `GPP_DIR_RST;
      dir12 <= `GPP_DIR_RST;
    end else if (cpu_wr_in) begin
      case (cpu_addr_in)
        `GPP_ADDR_DIR0: dir0 <= upd(dir0, `GPP_KEEP4, `GPP_FIX_DIR4);
        `GPP_ADDR_DIR2: dir2 <= upd(dir2, `GPP_KEEP4, `GPP_FIX_DIR4);
        `GPP_ADDR_DIR3: dir3 <= upd(dir3, `GPP_KEEP4, `GPP_FIX_DIR4);
        `GPP_ADDR_DIR4: dir4 <= upd(dir4, `GPP_KEEP8, `GPP_FIX_NONE);
        `GPP_ADDR_DIR12: dir12 <= upd(dir12, `GPP_KEEP4, `GPP_FIX_DIR4);
        default: dir0 <= dir0;
      endcase
    end
  end
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lat0 <= `GPP_REG_RST;
      lat2 <= `GPP_REG_RST;
      lat3 <= `GPP_REG_RST;
      lat4 <= `GPP_REG_RST;
      lat12 <= `GPP_REG_RST;
      lat13 <= `GPP_REG_RST;
    end else if (core_hold) begin
      lat0 <= `GPP_REG_RST;
      lat2 <= `GPP_REG_RST;
      lat3 <= `GPP_REG_RST;
      lat4 <= `GPP_REG_RST;
      lat12 <= `GPP_REG_RST;
      lat13 <= `GPP_REG_RST;
    end else if (cpu_wr_in) begin
      case (cpu_addr_in)
        `GPP_ADDR_LAT0: lat0 <= upd(lat0, `GPP_KEEP4, `GPP_FIX_NONE);
        `GPP_ADDR_LAT2: lat2 <= upd(lat2, `GPP_KEEP4, `GPP_FIX_NONE);
        `GPP_ADDR_LAT3: lat3 <= upd(lat3, `GPP_KEEP4, `GPP_FIX_NONE);
        `GPP_ADDR_LAT4: lat4 <= upd(lat4, `GPP_KEEP8, `GPP_FIX_NONE);
        `GPP_ADDR_LAT12: lat12 <= upd(lat12, `GPP_KEEP4, `GPP_FIX_NONE);
        `GPP_ADDR_LAT13: lat13 <= upd(lat13, `GPP_KEEP1, `GPP_FIX_NONE);
        default: lat0 <= lat0;
      endcase
    end
  end
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pu0 <= `GPP_REG_RST;
      pu2 <= `GPP_REG_RST;
      pu3 <= `GPP_REG_RST;
      pu4 <= `GPP_REG_RST;
      port12_pullup_select <= `GPP_REG_RST;
      an2 <= `GPP_REG_RST;
    end else if (core_hold) begin
      pu0 <= `GPP_REG_RST;
      pu2 <= `GPP_REG_RST;
      pu3 <= `GPP_REG_RST;
      pu4 <= `GPP_REG_RST;
      port12_pullup_select <= `GPP_REG_RST;
      an2 <= `GPP_REG_RST;
    end else if (cpu_wr_in) begin
      case (cpu_addr_in)
        `GPP_ADDR_PU0: pu0 <= upd(pu0, `GPP_KEEP4, `GPP_FIX_NONE);
        `GPP_ADDR_PU2: pu2 <= upd(pu2, `GPP_KEEP4, `GPP_FIX_NONE);
        `GPP_ADDR_PU3: pu3 <= upd(pu3, `GPP_KEEP4, `GPP_FIX_NONE);
        `GPP_ADDR_PU4: pu4 <= upd(pu4, `GPP_KEEP8, `GPP_FIX_NONE);
        `GPP_ADDR_PORT12_PULLUP_SELECT: port12_pullup_select <= upd(port12_pullup_select, `GPP_KEEP4, `GPP_FIX_NONE);
        `GPP_ADDR_AN2: an2 <= upd(an2, `GPP_KEEP4, `GPP_FIX_NONE);
        default: pu0 <= pu0;
      endcase
    end
  end
  // ==========================================================
  // pin drive, pull-ups and sharing
  logic [3:0] g12, a2;
  assign g12 = {1'b1, osc != GPP_OSC_XTAL, osc == GPP_OSC_INT, 1'b1};
  assign a2 = an2[3:0];
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      p0_pin_out <= 4'h0;
      p0_pin_oe_out <= 4'h0;
      p0_pullup_out <= 4'h0;
      p2_pin_out <= 4'h0;
      p2_pin_oe_out <= 4'h0;
      p2_pullup_out <= 4'h0;
      port2_analog_select_out <= 4'h0;
      p3_pin_out <= 4'h0;
      p3_pin_oe_out <= 4'h0;
      p3_pullup_out <= 4'h0;
      p4_pin_out <= 8'h00;
      p4_pin_oe_out <= 8'h00;
      p4_pullup_out <= 8'h00;
      p12_pin_out <= 4'h0;
      p12_pin_oe_out <= 4'h0;
      p12_pullup_out <= 4'h0;
      substitute_reset_output_pin_out <= 1'b0;
    end else begin
      p0_pin_out <= lat0[3:0];
      p0_pin_oe_out <= ~dir0[3:0];
      p0_pullup_out <= pu0[3:0] & dir0[3:0];
      p2_pin_out <= lat2[3:0];
      p2_pin_oe_out <= ~dir2[3:0] & ~a2;
      p2_pullup_out <= pu2[3:0] & dir2[3:0] & ~a2;
      port2_analog_select_out <= a2;
      p3_pin_out <= {lat3[3:2], lat3[1] | timer_output_a_in, lat3[0]};
      p3_pin_oe_out <= ~dir3[3:0];
      p3_pullup_out <= pu3[3:0] & dir3[3:0];
      // timer outputs need latch 0, serial transmit needs latch 1
      p4_pin_out <= {lat4[7:4], lat4[3] & serial_transmit_pin_in,
                     lat4[2] | timer_output_b_in, lat4[1:0]};
      p4_pin_oe_out <= ~dir4;
      p4_pullup_out <= pu4 & dir4;
      p12_pin_out <= lat12[3:0];
      p12_pin_oe_out <= ~dir12[3:0] & g12;
      p12_pullup_out <= port12_pullup_select[3:0] & dir12[3:0] & g12 & `GPP_PORT12_PULLUP_SELECT_MASK;
      substitute_reset_output_pin_out <= lat13[0] & !core_hold;
    end
  end
  // interrupt sources a, b and c follow the driven level in output mode, so a
  // change of latch raises a request; software masks it beforehand
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      timer_capture_input_a_out <= 1'b0;
      timer_capture_input_b_out <= 1'b0;
      ext_irq_a_out <= 1'b0;
      ext_irq_b_out <= 1'b0;
      ext_irq_c_out <= 1'b0;
      ext_irq_d_out <= 1'b0;
      serial_receive_pin_out <= 1'b0;
    end else begin
      timer_capture_input_a_out <= s3[0];
      timer_capture_input_b_out <= s3[1];
      ext_irq_a_out <= dir3[0] ? s3[0] : p3_pin_out[0];
      ext_irq_c_out <= dir3[1] ? s3[1] : p3_pin_out[1];
      ext_irq_d_out <= s4[1];
      ext_irq_b_out <= dir4[3] ? s4[3] : p4_pin_out[3];
      serial_receive_pin_out <= s4[4];
    end
  end
  // ==========================================================
  // register reads; unmapped addresses read zero
  logic [7:0] m12;
  assign m12 = {4'h0, g12};
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cpu_rdata_out <= 8'h00;
    end else if (cpu_rd_in) begin
      case (cpu_addr_in)
        `GPP_ADDR_LAT0: cpu_rdata_out <= rdv(dir0, lat0, {4'h0, s0});
        `GPP_ADDR_LAT2: cpu_rdata_out <= rdv(dir2, lat2, {4'h0, s2})
                                         & ~an2;
        `GPP_ADDR_LAT3: cpu_rdata_out <= rdv(dir3, lat3, {4'h0, s3})
                                         | {3'h0, rst_is_port & s_rst, 4'h0};
        `GPP_ADDR_LAT4: cpu_rdata_out <= rdv(dir4, lat4, s4);
        `GPP_ADDR_LAT12: cpu_rdata_out <= rdv(dir12, lat12, {4'h0, s12})
                                          & m12;
        `GPP_ADDR_LAT13: cpu_rdata_out <= lat13;
        `GPP_ADDR_DIR0: cpu_rdata_out <= dir0;
        `GPP_ADDR_DIR2: cpu_rdata_out <= dir2;
        `GPP_ADDR_DIR3: cpu_rdata_out <= dir3;
        `GPP_ADDR_DIR4: cpu_rdata_out <= dir4;
        `GPP_ADDR_DIR12: cpu_rdata_out <= dir12;
        `GPP_ADDR_PU0: cpu_rdata_out <= pu0;
        `GPP_ADDR_PU2: cpu_rdata_out <= pu2;
        `GPP_ADDR_PU3: cpu_rdata_out <= pu3;
        `GPP_ADDR_PU4: cpu_rdata_out <= pu4;
        `GPP_ADDR_PORT12_PULLUP_SELECT: cpu_rdata_out <= port12_pullup_select;
        `GPP_ADDR_AN2: cpu_rdata_out <= an2;
        default: cpu_rdata_out <= 8'h00;
      endcase
    end
  end
  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  dir_reset_a: assert property (core_hold |=> (dir0 == `GPP_DIR_RST)
    && (dir4 == `GPP_DIR_RST) && (dir12 == `GPP_DIR_RST))
    else $error("direction not input after hold");
  oe_follows_dir_a: assert property (
    ##1 p4_pin_oe_out == ~$past(dir4))
    else $error("port 4 driver not tied to direction");
  pullup_input_a: assert property (
    (p0_pullup_out & p0_pin_oe_out) == 4'h0
    && (p4_pullup_out & p4_pin_oe_out) == 8'h00)
    else $error("pull-up on driven pin");
  p12_pullup_a: assert property (p12_pullup_out[2:1] == 2'b00)
    else $error("pull-up on port 12 middle pin");
  p13_low_a: assert property (core_hold |=>
    !substitute_reset_output_pin_out)
    else $error("port 13 high during reset");
  read_mux_a: assert property (
    cpu_rd_in && cpu_addr_in == `GPP_ADDR_LAT4 && !cpu_wr_in
    |=> cpu_rdata_out == (($past(dir4) & $past(s4))
                          | (~$past(dir4) & $past(lat4))))
    else $error("port 4 read mux wrong");
  dir_upper_a: assert property (!core_hold && cpu_wr_in
    && cpu_addr_in == `GPP_ADDR_DIR0 |=> dir0[7:4] == 4'hf)
    else $error("upper direction bits changed");
  analog_off_a: assert property (an2[0] |=> !p2_pin_oe_out[0])
    else $error("analog pin still driven");
  xtal_pins_a: assert property (osc == GPP_OSC_XTAL
    |=> p12_pin_oe_out[2:1] == 2'b00)
    else $error("oscillator pins driven");
  pin_hold_a: assert property (state == GPP_RUN && pin_reset
    |=> state == GPP_CHECK ##1 !core_reset_n_out)
    else $error("reset pin low did not hold device");
  release_c: cover property (state == GPP_CHECK ##1 state == GPP_RUN);
  out_mode_c: cover property (p3_pin_oe_out[0] && $changed(ext_irq_a_out));
  analog_c: cover property (port2_analog_select_out != 4'h0);
  pin_reset_c: cover property (state == GPP_RUN ##1 state == GPP_CHECK);
endmodule

// ==== tb/gpp_pin_model.sv ====
// gpp_pin_model.sv: devices and pad on one general-purpose port
// assumes the bench sets each device's level and whether it drives
`timescale 1ns/1ps
// ==========================================================
// pin level resolution
module gpp_pin_model #(
  parameter int W = 4
) (
  input wire logic ref_clk_in,
  input wire logic [W-1:0] drv_in,
  input wire logic [W-1:0] oe_in,
  input wire logic [W-1:0] pullup_in,
  input wire logic [W-1:0] ext_in,
  input wire logic [W-1:0] ext_en_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] float_q = '0;
  // an undriven pin wanders each cycle so no stale level can be read
  always_ff @(posedge ref_clk_in) begin
    float_q <= ~level_out;
  end
  // devices let go of a pin while the chip drives it
  always_comb begin
    for (int b = 0; b < W; b++) begin
      if (oe_in[b]) begin
        level_out[b] = drv_in[b];
      end else if (ext_en_in[b]) begin
        level_out[b] = ext_in[b];
      end else if (pullup_in[b]) begin
        level_out[b] = 1'b1;
      end else begin
        level_out[b] = float_q[b];
      end
    end
  end
endmodule

// ==== tb/gpp_ports_tb_top.sv ====
// gpp_ports_tb_top.sv: self-checking bench for the port block
// assumes one gpp_pin_model per port (0, 2, 3, 4, 12) stands for the attached devices
`timescale 1ns/1ps
module gpp_ports_tb_top;
  // ==========================================================
  // signals
  logic ref_clk_in, nrst_in, cpu_wr_in, cpu_rd_in, cpu_bit_in;
  logic opt_reset_pin_is_port_in, core_reset_n_out;
  logic reset_shared_input_pin_in, substitute_reset_output_pin_out;
  logic timer_output_a_in, timer_output_b_in, serial_transmit_pin_in;
  logic timer_capture_input_a_out, timer_capture_input_b_out;
  logic ext_irq_a_out, ext_irq_b_out, ext_irq_c_out, ext_irq_d_out;
  logic serial_receive_pin_out;
  logic [15:0] cpu_addr_in;
  logic [2:0] cpu_bit_sel_in;
  logic [1:0] opt_osc_sel_in;
  logic [7:0] cpu_wdata_in, cpu_rdata_out, d, l, pu;
  logic [3:0] p0_pin_in, p0_pin_out, p0_pin_oe_out, p0_pullup_out;
  logic [3:0] p2_pin_in, p2_pin_out, p2_pin_oe_out, p2_pullup_out;
  logic [3:0] p3_pin_in, p3_pin_out, p3_pin_oe_out, p3_pullup_out;
  logic [3:0] p12_pin_in, p12_pin_out, p12_pin_oe_out, p12_pullup_out;
  logic [3:0] port2_analog_select_out;
  logic [7:0] p4_pin_in, p4_pin_out, p4_pin_oe_out, p4_pullup_out;
  logic [7:0] ext_v [5];
  logic [7:0] en_v [5];
  logic [7:0] oe_v [5];
  logic [7:0] out_v [5];
  logic [31:0] rng = 32'h0000003a;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int i;
  // table order of ports: 0, 2, 3, 4, 12
  localparam logic [15:0] lat_a [5] = '{16'hff00, 16'hff02, 16'hff03,
    16'hff04, 16'hff0c};
  localparam logic [15:0] dir_a [5] = '{16'hff20, 16'hff22, 16'hff23,
    16'hff24, 16'hff2c};
  localparam logic [7:0] keep_a [5] = '{8'h0f, 8'h0f, 8'h0f, 8'hff, 8'h0f};
  assign oe_v = '{{4'h0, p0_pin_oe_out}, {4'h0, p2_pin_oe_out},
    {4'h0, p3_pin_oe_out}, p4_pin_oe_out, {4'h0, p12_pin_oe_out}};
  assign out_v = '{{4'h0, p0_pin_out}, {4'h0, p2_pin_out},
    {4'h0, p3_pin_out}, p4_pin_out, {4'h0, p12_pin_out}};
  // ==========================================================
  // design and devices
  gpp_ports dut_u (.ref_clk_in, .nrst_in, .cpu_addr_in,
    .cpu_wr_in, .cpu_rd_in, .cpu_bit_in, .cpu_bit_sel_in, .cpu_wdata_in,
    .cpu_rdata_out, .opt_reset_pin_is_port_in, .opt_osc_sel_in,
    .core_reset_n_out, .p0_pin_in, .p0_pin_out, .p0_pin_oe_out,
    .p0_pullup_out, .p2_pin_in, .p2_pin_out, .p2_pin_oe_out, .p2_pullup_out,
    .port2_analog_select_out, .p3_pin_in, .p3_pin_out, .p3_pin_oe_out,
    .p3_pullup_out, .reset_shared_input_pin_in, .p4_pin_in, .p4_pin_out,
    .p4_pin_oe_out, .p4_pullup_out, .p12_pin_in, .p12_pin_out,
    .p12_pin_oe_out, .p12_pullup_out, .substitute_reset_output_pin_out,
    .timer_output_a_in, .timer_output_b_in, .serial_transmit_pin_in,
    .timer_capture_input_a_out, .timer_capture_input_b_out, .ext_irq_a_out,
    .ext_irq_b_out, .ext_irq_c_out, .ext_irq_d_out, .serial_receive_pin_out);
  gpp_pin_model m0_u (.ref_clk_in, .drv_in(p0_pin_out),
    .oe_in(p0_pin_oe_out), .pullup_in(p0_pullup_out), .ext_in(ext_v[0][3:0]),
    .ext_en_in(en_v[0][3:0]), .level_out(p0_pin_in));
  gpp_pin_model m2_u (.ref_clk_in, .drv_in(p2_pin_out),
    .oe_in(p2_pin_oe_out), .pullup_in(p2_pullup_out), .ext_in(ext_v[1][3:0]),
    .ext_en_in(en_v[1][3:0]), .level_out(p2_pin_in));
  gpp_pin_model m3_u (.ref_clk_in, .drv_in(p3_pin_out),
    .oe_in(p3_pin_oe_out), .pullup_in(p3_pullup_out), .ext_in(ext_v[2][3:0]),
    .ext_en_in(en_v[2][3:0]), .level_out(p3_pin_in));
  gpp_pin_model #(.W(8)) m4_u (.ref_clk_in, .drv_in(p4_pin_out),
    .oe_in(p4_pin_oe_out), .pullup_in(p4_pullup_out), .ext_in(ext_v[3]),
    .ext_en_in(en_v[3]), .level_out(p4_pin_in));
  gpp_pin_model m12_u (.ref_clk_in, .drv_in(p12_pin_out),
    .oe_in(p12_pin_oe_out), .pullup_in(p12_pullup_out),
    .ext_in(ext_v[4][3:0]), .ext_en_in(en_v[4][3:0]), .level_out(p12_pin_in));
  // ==========================================================
  // helpers
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end
  task automatic summarize();
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function logic [7:0] rnd8();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  // strobes rise one falling edge and drop at the next
  task automatic wr(input logic [15:0] a, input logic [7:0] v,
                    input logic b = 1'b0, input logic [2:0] s = 3'h0);
    cyc(1);
    cpu_addr_in = a;
    cpu_wdata_in = v;
    cpu_bit_in = b;
    cpu_bit_sel_in = s;
    cpu_wr_in = 1'b1;
    cyc(1);
    cpu_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    cyc(1);
    cpu_addr_in = a;
    cpu_rd_in = 1'b1;
    cyc(1);
    cpu_rd_in = 1'b0;
    cyc(1);
  endtask
  task automatic rst(input logic port_mode, input logic [1:0] osc);
    cyc(1);
    nrst_in = 1'b0;
    opt_reset_pin_is_port_in = port_mode;
    opt_osc_sel_in = osc;
    cyc(6);
    chk({7'h0, substitute_reset_output_pin_out}, 8'h00);
    chk(p4_pin_oe_out | oe_v[0] | oe_v[1] | oe_v[2] | oe_v[4], 8'h00);
    nrst_in = 1'b1;
  endtask
  task automatic wup();
    int n = 0;
    while (core_reset_n_out !== 1'b1 && n < 50) begin
      cyc(1);
      n++;
    end
    chk({7'h0, core_reset_n_out}, 8'h01);
  endtask
  // ==========================================================
  // scenarios
  initial begin
    {nrst_in, cpu_wr_in, cpu_rd_in, cpu_bit_in, timer_output_a_in} = '0;
    {timer_output_b_in, cpu_addr_in, cpu_bit_sel_in, cpu_wdata_in} = '0;
    {opt_reset_pin_is_port_in, opt_osc_sel_in} = '0;
    serial_transmit_pin_in = 1'b1;
    reset_shared_input_pin_in = 1'b1;
    for (i = 0; i < 5; i++) begin
      ext_v[i] = rnd8();
      en_v[i] = 8'hff;
    end
    rst(1'b0, 2'h0);
    wup();
    for (i = 0; i < 5; i++) begin
      rd(dir_a[i]);
      chk(cpu_rdata_out, 8'hff);
      rd(lat_a[i]);
      chk(cpu_rdata_out, ext_v[i] & keep_a[i]);
    end
    wr(16'hff24, 8'h00, 1'b1, 3'h5);
    rd(16'hff24);
    chk(cpu_rdata_out, 8'hdf);
    wr(16'hff20, 8'h00, 1'b1, 3'h6);
    rd(16'hff20);
    chk(cpu_rdata_out, 8'hff);
    ext_v[2] = 8'h03;
    ext_v[3] = 8'h1a;
    cyc(5);
    chk({4'h0, timer_capture_input_a_out, timer_capture_input_b_out,
         ext_irq_a_out, ext_irq_c_out}, 8'h0f);
    chk({5'h0, ext_irq_d_out, ext_irq_b_out, serial_receive_pin_out},
        8'h07);
    wr(16'hff04, 8'h08);
    wr(16'hff24, 8'hf7);
    cyc(4);
    chk({7'h0, ext_irq_b_out}, 8'h01);
    serial_transmit_pin_in = 1'b0;
    cyc(4);
    chk({6'h0, p4_pin_out[3], ext_irq_b_out}, 8'h00);
    wr(16'hff23, 8'h0d);
    timer_output_a_in = 1'b1;
    cyc(4);
    chk({6'h0, p3_pin_out[1], ext_irq_c_out}, 8'h03);
    timer_output_a_in = 1'b0;
    cyc(4);
    chk({6'h0, p3_pin_out[1], ext_irq_c_out}, 8'h00);
    wr(16'hff24, 8'hf3);
    timer_output_b_in = 1'b1;
    cyc(4);
    chk({7'h0, p4_pin_out[2]}, 8'h01);
    timer_output_b_in = 1'b0;
    serial_transmit_pin_in = 1'b1;
    wr(16'hff24, 8'hff);
    pu = rnd8();
    wr(16'hff34, pu);
    en_v[3] = 8'h00;
    cyc(5);
    chk(p4_pullup_out, pu);
    wr(16'hff30, pu);
    wr(16'hff33, pu);
    cyc(3);
    chk({p3_pullup_out, p0_pullup_out}, {pu[3:0] & 4'hd, pu[3:0]});
    rd(16'hff04);
    chk(cpu_rdata_out & pu, pu);
    en_v[3] = 8'hff;
    wr(16'hff24, 8'h00);
    cyc(3);
    chk(p4_pullup_out, 8'h00);
    wr(16'hff3c, 8'hff);
    wr(16'hff32, 8'h0f);
    wr(16'hff42, 8'h05);
    cyc(3);
    chk({4'h0, p12_pullup_out}, 8'h09);
    chk({4'h0, port2_analog_select_out}, 8'h05);
    chk({4'h0, p2_pullup_out}, 8'h0a);
    rd(16'hff02);
    chk(cpu_rdata_out, ext_v[1] & 8'h0a);
    wr(16'hff0d, 8'h01);
    cyc(3);
    chk({7'h0, substitute_reset_output_pin_out}, 8'h01);
    rst(1'b0, 2'h0);
    wup();
    for (int k = 0; k < 40; k++) begin
      i = rnd8() % 5;
      d = rnd8();
      l = rnd8();
      ext_v[i] = rnd8();
      wr(lat_a[i], l);
      wr(dir_a[i], d);
      cyc(4);
      chk(oe_v[i], ~d & keep_a[i]);
      chk(out_v[i] & ~d & keep_a[i], l & ~d & keep_a[i]);
      rd(lat_a[i]);
      chk(cpu_rdata_out, ((~d & l) | (d & ext_v[i])) & keep_a[i]);
      rd(dir_a[i]);
      chk(cpu_rdata_out, d | ~keep_a[i]);
    end
    reset_shared_input_pin_in = 1'b0;
    rst(1'b0, 2'h0);
    cyc(20);
    chk({7'h0, core_reset_n_out}, 8'h00);
    reset_shared_input_pin_in = 1'b1;
    wup();
    wr(16'hff24, 8'h00);
    cyc(3);
    reset_shared_input_pin_in = 1'b0;
    cyc(6);
    chk({7'h0, core_reset_n_out}, 8'h00);
    chk(p4_pin_oe_out, 8'h00);
    reset_shared_input_pin_in = 1'b1;
    wup();
    rd(16'hff24);
    chk(cpu_rdata_out, 8'hff);
    rst(1'b1, 2'h0);
    wup();
    reset_shared_input_pin_in = 1'b0;
    cyc(8);
    chk({7'h0, core_reset_n_out}, 8'h01);
    rd(16'hff03);
    chk(cpu_rdata_out & 8'h10, 8'h00);
    reset_shared_input_pin_in = 1'b1;
    cyc(4);
    rd(16'hff03);
    chk(cpu_rdata_out & 8'h10, 8'h10);
    for (int k = 0; k < 4; k++) begin
      rst(1'b1, k[1:0]);
      wup();
      wr(16'hff2c, 8'h00);
      cyc(3);
      chk({4'h0, p12_pin_oe_out}, {5'h01, k != 1, k == 0, 1'b1});
    end
    summarize();
  end
endmodule
